// File: design/touch_notify_defs.svh
`ifndef TOUCH_NOTIFY_DEFS_SVH
`define TOUCH_NOTIFY_DEFS_SVH

// message store depth in entries and message width in bits
`define MSG_DEPTH          16
`define MSG_WIDTH          8
`define MSG_COUNT_WIDTH    5
// command codes written into the command object
`define CMD_WIDTH          8
`define CMD_NONE           8'h00
`define CMD_SAVE           8'h55
`define CMD_RESET          8'h01
// hid-side power state argument of the set power request
`define PWR_ON             1'b0
`define PWR_SLEEP          1'b1
// startup message pushed into the store after reset
`define STARTUP_MSG        8'h01
// time from reset release to the startup message, in us
`define STARTUP_DELAY_US   10
`define CLK_MHZ            100

`endif

// File: design/touch_notify_pkg.sv
package touch_notify_pkg;
  `include "touch_notify_defs.svh"

  typedef enum logic [1:0] {
    st_startup,
    st_run,
    st_suspend
  } notify_state_t;

  typedef logic [`MSG_WIDTH-1:0] msg_t;
  typedef logic [`CMD_WIDTH-1:0] cmd_t;
endpackage

// File: design/strap_sync.sv
// two-stage synchroniser for the interface-select strap
module strap_sync (
  input  wire logic clk_sys_i, // system clock
  input  wire logic rst_n_i,   // synchronous reset, active low
  input  wire logic async_i,   // asynchronous level
  output logic      sync_o     // synchronised level
);
  typedef struct packed {
    logic s1;
    logic s2;
  } sync_state_t;

  sync_state_t r;
  sync_state_t next_r;

  always_comb begin
    next_r    = r;
    next_r.s1 = async_i;
    next_r.s2 = r.s1;
  end

  // strap idles high, so reset to the plain two-wire reading
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      r <= '{s1: 1'b1, s2: 1'b1};
    end else begin
      r <= next_r;
    end
  end

  assign sync_o = r.s2;
endmodule

// File: design/touch_host_notify.sv
// What this block does
// - message pending line is active low open drain: only ever pulled low.
// - plain mode: assert pending line whenever a new message enters store.
// - plain mode: after reset the startup message makes the pending line go low.
// - strap tied low selects hid mode, otherwise plain two-wire mode.
// - hid set power sleep command enters a low-power suspend state.
// - device executes the command code written to command object.
// - all status is held in the message store, read by host.
// - hid mode: messages are pushed automatically as input reports.
// - every configuration field resets to zero, a safe disabled default.
// - save command makes configuration persistent in nonvolatile memory.
// - debug, store, user data and count objects are read only.
// - hid mode: any memory-map read or write stops auto delivery.
`include "touch_notify_defs.svh"
module touch_host_notify
  import touch_notify_pkg::*;
#(
  parameter int DEPTH   = `MSG_DEPTH,
  parameter int MSG_W   = `MSG_WIDTH,
  parameter int CNT_W   = `MSG_COUNT_WIDTH
) (
  input  wire logic             clk_sys_i,       // system clock
  input  wire logic             rst_n_i,         // sync reset, active low
  input  wire logic             strap_i,         // interface select pin
  input  wire logic             msg_valid_i,     // new message from core
  input  wire logic [MSG_W-1:0] msg_data_i,      // message contents
  output logic                  msg_ready_o,     // store can accept
  input  wire logic             store_read_i,    // host reads store head
  output logic      [MSG_W-1:0] store_data_o,    // store head, read only
  output logic                  store_empty_o,   // nothing pending
  output logic      [CNT_W-1:0] msg_count_o,     // message count object
  input  wire logic             cmd_write_i,     // command object write
  input  wire logic [`CMD_WIDTH-1:0] cmd_code_i, // written command code
  output logic                  save_req_o,      // pulse: store to nvm
  output logic                  reset_req_o,     // pulse: software reset
  input  wire logic             nvm_busy_i,      // nvm write in progress
  input  wire logic             auto_on_i,       // hid auto-return request
  input  wire logic             auto_off_i,      // hid null command
  input  wire logic             map_access_i,    // hid memory-map access
  output logic                  report_valid_o,  // hid input report out
  output logic      [MSG_W-1:0] report_data_o,   // input report payload
  input  wire logic             report_ready_i,  // report taken by link
  input  wire logic             set_power_i,     // hid set power command
  input  wire logic             set_power_arg_i, // 1 sleep, 0 on
  output logic                  suspend_o,       // low-power state
  output logic                  hid_mode_o,      // strap decoded
  output logic                  pending_n_o,     // pending line level
  output logic                  pending_oe_o     // pending line pull low
);
  localparam int STARTUP_CYC_I = `STARTUP_DELAY_US * `CLK_MHZ;
  localparam int PTR_W = $clog2(DEPTH);
  localparam int DLY_W = $clog2(STARTUP_CYC_I + 1);
  localparam logic [DLY_W-1:0] STARTUP_CYC = DLY_W'(STARTUP_CYC_I);
  localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(DEPTH);

  typedef struct packed {
    notify_state_t      state;
    logic [DLY_W-1:0]   delay;
    logic [PTR_W-1:0]   wr_ptr;
    logic [PTR_W-1:0]   rd_ptr;
    logic [CNT_W-1:0]   count;
    logic               auto_en;
    logic               report_valid;
    logic [MSG_W-1:0]   report_data;
    logic               save_req;
    logic               save_wait;
    logic               reset_req;
    logic               suspend;
    logic               pending_oe;
    logic               msg_ready;
    logic [MSG_W-1:0]   head;
    logic               empty;
  } core_state_t;

  core_state_t r;
  core_state_t next_r;
  logic [MSG_W-1:0] store_mem [DEPTH];
  logic strap_sync_q;
  logic hid_mode;
  logic push;
  logic host_pop;
  logic auto_pop;
  logic pop;
  logic [MSG_W-1:0] push_data;
  logic [PTR_W-1:0] head_ptr;

  strap_sync u_strap_sync (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .async_i   (strap_i),
    .sync_o    (strap_sync_q)
  );

  assign hid_mode = ~strap_sync_q;

  // the startup message shares the store with core messages
  always_comb begin
    push      = 1'b0;
    push_data = msg_data_i;
    if (r.state == st_startup && r.delay == '0) begin
      push      = r.count != DEPTH_C;
      push_data = `STARTUP_MSG;
    end else if (r.state != st_startup) begin
      push = msg_valid_i && r.msg_ready;
    end
  end

  // host reads are served in either mode; auto delivery drains in hid mode
  assign host_pop = store_read_i && r.count != '0;
  assign auto_pop = !host_pop && hid_mode && r.auto_en && !r.suspend
                    && r.count != '0
                    && (!r.report_valid || report_ready_i);
  assign pop = host_pop || auto_pop;
  assign head_ptr = pop ? PTR_W'(r.rd_ptr + 1'b1) : r.rd_ptr;

  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      store_mem[r.wr_ptr] <= push_data;
    end
  end

  always_comb begin
    next_r           = r;
    next_r.save_req  = 1'b0;
    next_r.reset_req = 1'b0;

    case (r.state)
      st_startup: begin
        if (r.delay != '0) begin
          next_r.delay = r.delay - 1'b1;
        end else begin
          next_r.state = st_run;
        end
      end
      st_run: begin
        if (hid_mode && set_power_i && set_power_arg_i == `PWR_SLEEP) begin
          next_r.state   = st_suspend;
          next_r.suspend = 1'b1;
        end
      end
      st_suspend: begin
        if (set_power_i && set_power_arg_i == `PWR_ON) begin
          next_r.state   = st_run;
          next_r.suspend = 1'b0;
        end
      end
      default: begin
        next_r.state = st_startup;
      end
    endcase

    if (push) begin
      next_r.wr_ptr = PTR_W'(r.wr_ptr + 1'b1);
    end
    if (pop) begin
      next_r.rd_ptr = PTR_W'(r.rd_ptr + 1'b1);
    end
    case ({push, pop})
      2'b10:   next_r.count = r.count + 1'b1;
      2'b01:   next_r.count = r.count - 1'b1;
      default: next_r.count = r.count;
    endcase
    next_r.msg_ready = next_r.count != DEPTH_C && r.state != st_startup;

    // head mirrors the entry at the read pointer after this edge
    if (push && next_r.wr_ptr == PTR_W'(head_ptr + 1'b1)
        && r.count == (pop ? CNT_W'(1) : '0)) begin
      next_r.head = push_data;
    end else begin
      next_r.head = store_mem[head_ptr];
    end

    // map access wins over a start request in the same cycle
    if (map_access_i) begin
      next_r.auto_en = 1'b0;
    end else if (auto_off_i) begin
      next_r.auto_en = 1'b0;
    end else if (auto_on_i && hid_mode) begin
      next_r.auto_en = 1'b1;
    end
    if (!hid_mode) begin
      next_r.auto_en = 1'b0;
    end

    if (auto_pop) begin
      next_r.report_valid = 1'b1;
      next_r.report_data  = r.head;
    end else if (report_ready_i) begin
      next_r.report_valid = 1'b0;
    end

    // one save at a time; a save issued before the previous save's nvm write ends is dropped
    if (cmd_write_i && cmd_code_i == `CMD_SAVE && !r.save_wait) begin
      next_r.save_req  = 1'b1;
      next_r.save_wait = 1'b1;
    end else if (r.save_wait && !r.save_req && !nvm_busy_i) begin
      next_r.save_wait = 1'b0;
    end
    if (cmd_write_i && cmd_code_i == `CMD_RESET) begin
      next_r.reset_req = 1'b1;
    end

    // plain mode pull-low follows store occupancy
    next_r.pending_oe = !hid_mode && next_r.count != '0;
    // registered so the empty flag leaves the block straight from a flop
    next_r.empty      = next_r.count == '0;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      r       <= '0;
      r.state <= st_startup;
      r.delay <= STARTUP_CYC;
      r.empty <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign msg_ready_o    = r.msg_ready;
  assign store_data_o   = r.head;
  assign store_empty_o  = r.empty;
  assign msg_count_o    = r.count;
  assign save_req_o     = r.save_req;
  assign reset_req_o    = r.reset_req;
  assign report_valid_o = r.report_valid;
  assign report_data_o  = r.report_data;
  assign suspend_o      = r.suspend;
  assign hid_mode_o     = hid_mode;
  assign pending_n_o    = 1'b0;
  assign pending_oe_o   = r.pending_oe;
endmodule

// File: test/touch_host_notify_assertions.sv
module touch_host_notify_chk #(
  parameter int CNT_W = 5,
  parameter int MSG_W = 8
) (
  input wire logic             clk_sys_i,
  input wire logic             rst_n_i,
  input wire logic             strap_i,
  input wire logic             msg_valid_i,
  input wire logic             msg_ready_o,
  input wire logic             store_read_i,
  input wire logic             store_empty_o,
  input wire logic [CNT_W-1:0] msg_count_o,
  input wire logic             cmd_write_i,
  input wire logic [7:0]       cmd_code_i,
  input wire logic             save_req_o,
  input wire logic             reset_req_o,
  input wire logic             map_access_i,
  input wire logic             report_valid_o,
  input wire logic [MSG_W-1:0] report_data_o,
  input wire logic             report_ready_i,
  input wire logic             set_power_i,
  input wire logic             set_power_arg_i,
  input wire logic             suspend_o,
  input wire logic             hid_mode_o,
  input wire logic             pending_n_o,
  input wire logic             pending_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  property p_pend_low; pending_n_o == 1'b0; endproperty
  a_pend_low: assert property (p_pend_low)
    else $error("pending line driven high");
  property p_pend_on; !hid_mode_o && msg_count_o != 0 |-> pending_oe_o;
  endproperty
  a_pend_on: assert property (p_pend_on)
    else $error("pending line not pulled while messages wait");
  property p_pend_off; msg_count_o == 0 |-> !pending_oe_o; endproperty
  a_pend_off: assert property (p_pend_off)
    else $error("pending line held with empty store");
  // cycles since reset release without the startup pull on the pending line
  logic [10:0] boot_cnt;
  logic        boot_wait;
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      boot_cnt  <= '0;
      boot_wait <= 1'b1;
    end else if (pending_oe_o || !strap_i) begin
      boot_wait <= 1'b0;
    end else if (boot_wait) begin
      boot_cnt <= boot_cnt + 11'h1;
    end
  end
  // 11'h3f2: startup delay plus a small margin
  property p_boot; boot_wait |-> boot_cnt <= 11'h3f2; endproperty
  a_boot: assert property (p_boot)
    else $error("no startup notification");
  property p_hid_quiet; hid_mode_o |-> !pending_oe_o; endproperty
  a_hid_quiet: assert property (p_hid_quiet)
    else $error("pending line used in hid mode");
  property p_sleep;
    set_power_i && set_power_arg_i && hid_mode_o |=> suspend_o;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep request ignored");
  property p_reset_cmd;
    cmd_write_i && cmd_code_i == 8'h01 |=> reset_req_o ##1 !reset_req_o;
  endproperty
  a_reset_cmd: assert property (p_reset_cmd)
    else $error("reset command not one pulse");
  property p_save;
    $rose(save_req_o) |-> $past(cmd_write_i) && $past(cmd_code_i) == 8'h55;
  endproperty
  a_save: assert property (p_save)
    else $error("save pulse without save command");
  property p_pop;
    store_read_i && !store_empty_o && !(msg_valid_i && msg_ready_o)
      |=> msg_count_o == $past(msg_count_o) - 1'b1;
  endproperty
  a_pop: assert property (p_pop)
    else $error("pop did not lower count");
  property p_hold;
    report_valid_o && !report_ready_i
      |=> report_valid_o && $stable(report_data_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("report dropped before taken");
  property p_stop; map_access_i ##2 !report_valid_o |=> !report_valid_o [*4];
  endproperty
  a_stop: assert property (p_stop)
    else $error("reports continue after map access");
endmodule
bind touch_host_notify touch_host_notify_chk #(.CNT_W(CNT_W), .MSG_W(MSG_W))
  u_chk (.*);

// File: test/host_model.sv
module host_model (
  input  wire logic clk_sys_i,      // system clock
  input  wire logic pend_line_i,    // pending wire level
  input  wire logic report_valid_i, // report offered
  input  wire logic go_i,           // host active
  output logic      store_read_o,   // pop store head
  output logic      report_ready_o  // take report
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] ph = 3'h0;
  initial begin
    store_read_o = 1'b0;
    report_ready_o = 1'b0;
  end
  // store reads and report takes only happen while go_i is high
  // link is slow on purpose: only takes reports in half the cycles
  always @(negedge clk_sys_i) begin
    ph <= ph + 3'h1;
    store_read_o <= go_i && !pend_line_i;
    report_ready_o <= go_i && report_valid_i && ph[1];
  end
endmodule

// File: test/tb_touch_host_notify.sv
module tb_touch_host_notify;
  import touch_notify_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i, rst_n_i, strap_i, msg_valid_i, store_read_i, cmd_write_i;
  logic nvm_busy_i, auto_on_i, auto_off_i, map_access_i, report_ready_i;
  logic set_power_i, set_power_arg_i, msg_ready_o, store_empty_o, save_req_o;
  logic reset_req_o, report_valid_o, suspend_o, hid_mode_o, pending_n_o;
  logic pending_oe_o, go, pend;
  msg_t msg_data_i, store_data_o, report_data_o;
  cmd_t cmd_code_i;
  logic [4:0] msg_count_o;
  msg_t q[$];
  int miscompares = 0;
  int cmp_count = 0;
  logic [31:0] lfsr = 32'hd0ad7232;
  assign pend = pending_oe_o ? pending_n_o : 1'b1; // board pull-up
  touch_host_notify u_dut (.*);
  host_model u_host (.clk_sys_i(clk_sys_i), .pend_line_i(pend),
    .report_valid_i(report_valid_o), .go_i(go),
    .store_read_o(store_read_i), .report_ready_o(report_ready_i));
  function automatic msg_t nxt();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (miscompares == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic restart(input logic s);
    rst_n_i = 1'b0;
    strap_i = s;
    q = {};
    repeat (2) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    q.push_back(8'h01); // startup message checked like any other
  endtask
  task automatic push(input int n);
    repeat (n) begin
      msg_valid_i = 1'b1;
      msg_data_i = nxt();
      while (!msg_ready_o) @(negedge clk_sys_i);
      @(negedge clk_sys_i);
    end
    msg_valid_i = 1'b0;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk_sys_i);
    s = 1'b0;
  endtask
  always @(posedge clk_sys_i) if (rst_n_i) begin
    if (msg_valid_i && msg_ready_o) q.push_back(msg_data_i);
    if (store_read_i && !store_empty_o)
      chk(store_data_o, q.pop_front());
    if (report_valid_o && report_ready_i)
      chk(report_data_o, q.pop_front());
  end
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    #60us;
    miscompares++;
    tally_and_finish();
  end
  initial begin
    {msg_valid_i, cmd_write_i, nvm_busy_i, auto_on_i, auto_off_i} = '0;
    {map_access_i, set_power_i, set_power_arg_i, go} = '0;
    msg_data_i = '0;
    cmd_code_i = '0;
    restart(1'b1);
    repeat (1100) if (pend) @(negedge clk_sys_i);
    chk({7'h0, pend}, 8'h00);
    push(15);
    chk({3'h0, msg_count_o}, 8'h10);
    chk({7'h0, msg_ready_o}, 8'h00);
    go = 1'b1;
    repeat (40) @(negedge clk_sys_i);
    chk({7'h0, pend}, 8'h01);
    push(5);
    repeat (20) @(negedge clk_sys_i);
    chk({7'h0, store_empty_o}, 8'h01);
    cmd_code_i = 8'h55;
    pulse(cmd_write_i);
    chk({6'h0, save_req_o, reset_req_o}, 8'h02);
    cmd_code_i = 8'h01;
    @(negedge clk_sys_i);
    pulse(cmd_write_i);
    chk({6'h0, save_req_o, reset_req_o}, 8'h01);
    // only a handful of saves, far below the write endurance
    nvm_busy_i = 1'b1;
    cmd_code_i = 8'h55;
    @(negedge clk_sys_i);
    pulse(cmd_write_i);
    chk({7'h0, save_req_o}, 8'h01);
    @(negedge clk_sys_i);
    pulse(cmd_write_i);
    chk({7'h0, save_req_o}, 8'h00);
    nvm_busy_i = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    pulse(cmd_write_i);
    chk({7'h0, save_req_o}, 8'h01);
    restart(1'b0);
    repeat (1100) @(negedge clk_sys_i);
    chk({6'h0, hid_mode_o, pending_oe_o}, 8'h02);
    pulse(auto_on_i);
    push(6);
    repeat (60) @(negedge clk_sys_i);
    chk({3'h0, msg_count_o}, 8'h00);
    pulse(map_access_i);
    repeat (3) @(negedge clk_sys_i);
    push(1);
    repeat (20) @(negedge clk_sys_i);
    chk({2'h0, msg_count_o, report_valid_o}, 8'h02);
    pulse(auto_on_i); // reporting switched on last
    repeat (10) @(negedge clk_sys_i);
    chk({3'h0, msg_count_o}, 8'h00);
    pulse(auto_off_i);
    push(1);
    repeat (20) @(negedge clk_sys_i);
    chk({2'h0, msg_count_o, report_valid_o}, 8'h02);
    set_power_arg_i = 1'b1;
    pulse(set_power_i);
    chk({7'h0, suspend_o}, 8'h01);
    set_power_arg_i = 1'b0;
    @(negedge clk_sys_i);
    pulse(set_power_i);
    chk({7'h0, suspend_o}, 8'h00);
    tally_and_finish();
  end
endmodule
